/* hw/dot_matrix_defs.vh */
// Register map, field positions, reset values and timing counts of the dot-matrix loader
`ifndef DOT_MATRIX_DEFS_VH
`define DOT_MATRIX_DEFS_VH

// Register byte offsets on the APB word bus
`define OFF_CHAR_CODE 8'h00
`define OFF_CONTROL 8'h04
`define OFF_DIAG_CONTROL 8'h08
`define OFF_STATUS 8'h0c
`define OFF_WORD1 8'h10
`define OFF_WORD2 8'h14
`define OFF_HOST_INPUT 8'h18
`define OFF_IMAGE_ADDR 8'h1c
`define OFF_MEM_INDEX 8'h20
`define OFF_MEM_DATA 8'h24

// Control register fields
`define CTL_CONTINUOUS 0
`define CTL_REVERSE 1
`define CTL_LAST_CHAR 2
`define CTL_RESET 3'h0

// Diagnostic control register: value that starts a new line, reset value
`define DIAG_NEW_LINE 8'h08
`define DIAG_RESET 8'h00
`define DIAG_SEL_STATUS 1

// Status register fields
`define ST_BUSY 0
`define ST_DATA_READY 1
`define ST_MOTOR_RUN 2
`define ST_STOP_LATCH 3
`define ST_LATE_PEND 4
`define ST_BACKSPACE 5

// Image address high bytes of the three storage modules
`define MOD_HI_0 8'hb8
`define MOD_HI_1 8'hb9
`define MOD_HI_2 8'hba
// Fixed high byte of the index table
`define TABLE_HI 8'hf9
// Number of images held and number of 32-bit words of image storage
`define IMAGE_COUNT 88
`define STORE_WORDS 192
// Step from the first image word to the second
`define WORD_STEP 8'h04
// Bytes gated per character
`define BYTES_PER_CHAR 3'd7

// Stepping-motor stop sequence length
`define CLK_PERIOD_NS 10
`define STOP_TIME_NS 40
`define STOP_CYCLES ((`STOP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* hw/image_index_table.v */
// Index table: gives the low image-address byte for a character code
`timescale 1ns/1ns
`default_nettype none
`include "dot_matrix_defs.vh"

module image_index_table (
	input wire [7:0] table_addr,
	output reg [7:0] table_data
);
	wire [6:0] idx;
	assign idx = table_addr[6:0];

	// Entries step by eight; holes in the code space read zero
	always @* begin
		table_data = 8'h00;
		if (idx >= 7'h40) begin
			table_data = {idx[4:0], 3'h0};
		end else if (idx <= 7'h09) begin
			table_data = {idx[4:0], 3'h0};
		end else if (idx >= 7'h11 && idx <= 7'h19) begin
			table_data = {idx[4:0] - 5'h07, 3'h0};
		end else if (idx >= 7'h22 && idx <= 7'h29) begin
			table_data = {idx[4:0] + 5'h11, 3'h0};
		end
	end
endmodule // image_index_table
`default_nettype wire

/* hw/image_store.v */
// Image storage: three modules of 64 words each, written by software
`timescale 1ns/1ns
`default_nettype none
`include "dot_matrix_defs.vh"

module image_store (
	input wire pclk,
	input wire wr_en,
	input wire [7:0] wr_index,
	input wire [31:0] wr_data,
	input wire [7:0] rd_index_a,
	output wire [31:0] rd_data_a,
	input wire [7:0] rd_index_b,
	output wire [31:0] rd_data_b
);
	reg [31:0] mem [0:`STORE_WORDS-1];

	// No reset on the array: images are loaded by software before printing
	always @(posedge pclk) begin
		if (wr_en && wr_index < `STORE_WORDS) begin
			mem[wr_index] <= wr_data;
		end
	end

	assign rd_data_a = (rd_index_a < `STORE_WORDS) ? mem[rd_index_a] : 32'h0000_0000;
	assign rd_data_b = (rd_index_b < `STORE_WORDS) ? mem[rd_index_b] : 32'h0000_0000;
endmodule // image_store
`default_nettype wire

/* hw/char_to_dot_matrix_loader.v */
// Character-to-dot-matrix loader with APB registers, byte gating and motor control
//
// How it works
// - code bits 1,2 pick image high byte: 00/01 B8, 10 B9, 11 BA.
// - 88 images held across three storage modules, one per character.
// - code with bit 0 forced to one indexes table under high byte F9.
// - table byte is low image-address byte pointing at first image word.
// - table spans F980-F9FF, one byte each, steps of eight, holes zero.
// - after first word, image address grows by four, second word fetched.
// - control bit clear: both strobes, word written into both halves.
// - control bit set: only pair strobe, word written into second half.
// - held image bits go to print wires in parallel, byte by byte.
// - space loads like any character, with an all-zero image.
// - writing 08 to diagnostic control starts carrier return, no translation.
// - late data in continuous writing gives stop, backspace and retry.
// - block starts, runs, stops and reverses the head stepper motor.
// - one stop sequence for all modes and directions, begun by stop latch.
// - continuous running for writing, one character at a time for keyboard.
// - input register takes keyboard codes untranslated, or diagnostic signals.
// - diagnostic control register is eight latches driving control lines.
// - two image words per character, loaded in separate cycles.
// - byte seven and bit seven of each byte are unused zeros.
// - late-data backspace runs automatically; no manual trigger exists.
`timescale 1ns/1ns
`default_nettype none
`include "dot_matrix_defs.vh"

module char_to_dot_matrix_loader (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire pe_pulse,
	input wire kb_strobe,
	input wire [7:0] kb_char,
	output reg [6:0] print_wire,
	output reg load_first_half_strobe,
	output reg load_pair_strobe,
	output reg data_ready,
	output reg motor_run,
	output reg motor_reverse,
	output reg stop_signal,
	output reg backspace,
	output reg new_line,
	output reg [7:0] diag_lines
);
	////////////////////////////////////////////////////////////////////////////////
	// Functions

	// Module select from code bits 1 and 2 (bit 0 is the most significant)
	function [7:0] module_hi;
		input [7:0] code;
		begin
			case (code[6:5])
				2'b10: module_hi = `MOD_HI_1;
				2'b11: module_hi = `MOD_HI_2;
				default: module_hi = `MOD_HI_0;
			endcase
		end
	endfunction

	// Word index into the image store from a 16-bit image address
	function [7:0] store_index;
		input [15:0] addr;
		begin
			store_index = {addr[9:8], addr[7:2]};
		end
	endfunction

	// Image byte n of the two words; bit seven (lsb) is dropped
	function [6:0] image_byte;
		input [31:0] w1;
		input [31:0] w2;
		input [2:0] n;
		begin
			case (n)
				3'd0: image_byte = w1[31:25];
				3'd1: image_byte = w1[23:17];
				3'd2: image_byte = w1[15:9];
				3'd3: image_byte = w1[7:1];
				3'd4: image_byte = w2[31:25];
				3'd5: image_byte = w2[23:17];
				3'd6: image_byte = w2[15:9];
				default: image_byte = 7'h00;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// State and registers

	localparam S_IDLE = 3'd0;
	localparam S_SEL = 3'd1;
	localparam S_TBL = 3'd2;
	localparam S_W1 = 3'd3;
	localparam S_W2 = 3'd4;
	localparam S_HOLD = 3'd5;

	localparam M_IDLE = 2'd0;
	localparam M_RUN = 2'd1;
	localparam M_STOP = 2'd2;
	localparam M_BACK = 2'd3;

	reg [2:0] seq_reg;
	reg [1:0] mot_reg;
	reg [7:0] char_reg;
	reg [2:0] control_reg;
	reg [7:0] diag_control_reg;
	reg [7:0] host_input_reg;
	reg [31:0] word1_reg;
	reg [31:0] word2_reg;
	reg [15:0] img_addr_reg;
	reg [7:0] mem_index_reg;
	reg [2:0] byte_cnt_reg;
	reg [7:0] stop_cnt_reg;
	reg stop_latch_reg;
	reg late_pend_reg;

	wire [7:0] table_data;
	wire [31:0] img_word;
	wire [31:0] mem_rd_word;
	wire wr_acc;
	wire rd_setup;
	wire [7:0] reg_off;
	wire start_char;
	wire gate_byte;
	wire late_data;
	wire last_byte;

	assign reg_off = paddr[7:0];
	assign rd_setup = psel && !penable;
	assign wr_acc = psel && penable && pready && pwrite;
	// Writing a character while a load is in progress or data is held is ignored
	assign start_char = wr_acc && reg_off == `OFF_CHAR_CODE && paddr[31:8] == 24'h000000
		&& seq_reg == S_IDLE;
	// Emitter pulse while running with a character held gates the next byte
	assign gate_byte = pe_pulse && mot_reg == M_RUN && data_ready;
	// Emitter pulse while running in continuous mode with nothing loaded is late data
	assign late_data = pe_pulse && mot_reg == M_RUN && !data_ready
		&& control_reg[`CTL_CONTINUOUS] && !stop_latch_reg;
	assign last_byte = byte_cnt_reg == `BYTES_PER_CHAR - 3'd1;

	////////////////////////////////////////////////////////////////////////////////
	// Lookup table and image storage

	image_index_table u_table (
		.table_addr({1'b1, char_reg[6:0]}),
		.table_data(table_data)
	);

	// Store holds all 88 images; software fills it through the data window
	image_store u_store (
		.pclk(pclk),
		.wr_en(wr_acc && reg_off == `OFF_MEM_DATA && paddr[31:8] == 24'h000000),
		.wr_index(mem_index_reg),
		.wr_data(pwdata),
		.rd_index_a(store_index(img_addr_reg)),
		.rd_data_a(img_word),
		.rd_index_b(mem_index_reg),
		.rd_data_b(mem_rd_word)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Translation sequencer: module select, table read, word 1, word 2

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_reg <= S_IDLE;
			char_reg <= 8'h00;
			img_addr_reg <= 16'h0000;
			word1_reg <= 32'h0000_0000;
			word2_reg <= 32'h0000_0000;
			load_first_half_strobe <= 1'b0;
			load_pair_strobe <= 1'b0;
			data_ready <= 1'b0;
			byte_cnt_reg <= 3'd0;
		end else begin
			load_first_half_strobe <= 1'b0;
			load_pair_strobe <= 1'b0;
			case (seq_reg)
				S_IDLE: begin
					// Space follows the same path; its image is all zeros
					if (start_char) begin
						char_reg <= pwdata[7:0];
						seq_reg <= S_SEL;
					end
				end
				S_SEL: begin
					img_addr_reg[15:8] <= module_hi(char_reg);
					seq_reg <= S_TBL;
				end
				S_TBL: begin
					img_addr_reg[7:0] <= table_data;
					seq_reg <= S_W1;
				end
				S_W1: begin
					// Control bit clear: word lands in both halves
					word1_reg <= img_word;
					word2_reg <= img_word;
					load_first_half_strobe <= 1'b1;
					load_pair_strobe <= 1'b1;
					img_addr_reg[7:0] <= img_addr_reg[7:0] + `WORD_STEP;
					seq_reg <= S_W2;
				end
				S_W2: begin
					// Control bit set: only the second half takes the word
					word2_reg <= img_word;
					load_pair_strobe <= 1'b1;
					data_ready <= 1'b1;
					byte_cnt_reg <= 3'd0;
					seq_reg <= S_HOLD;
				end
				S_HOLD: begin
					// Ready holds until all seven bytes have been gated out
					if (gate_byte) begin
						if (last_byte) begin
							data_ready <= 1'b0;
							byte_cnt_reg <= 3'd0;
							seq_reg <= S_IDLE;
						end else begin
							byte_cnt_reg <= byte_cnt_reg + 3'd1;
						end
					end
				end
				default: seq_reg <= S_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Print wire drive: only in the cycle after an emitter pulse, bit seven never fires

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			print_wire <= 7'h00;
		end else if (gate_byte) begin
			print_wire <= image_byte(word1_reg, word2_reg, byte_cnt_reg);
		end else begin
			print_wire <= 7'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Stepping motor: start, run, shared stop sequence, automatic backspace

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mot_reg <= M_IDLE;
			motor_run <= 1'b0;
			motor_reverse <= 1'b0;
			stop_signal <= 1'b0;
			backspace <= 1'b0;
			stop_latch_reg <= 1'b0;
			late_pend_reg <= 1'b0;
			stop_cnt_reg <= 8'h00;
		end else begin
			backspace <= 1'b0;
			case (mot_reg)
				M_IDLE: begin
					// A held character starts the head in the chosen direction
					if (data_ready) begin
						mot_reg <= M_RUN;
						motor_run <= 1'b1;
						motor_reverse <= control_reg[`CTL_REVERSE];
					end
				end
				M_RUN: begin
					// Keyboard mode stops after each character; writing runs on
					// until the last character or a late-data event
					if (late_data) begin
						stop_latch_reg <= 1'b1;
						late_pend_reg <= 1'b1;
					end else if (gate_byte && last_byte && (!control_reg[`CTL_CONTINUOUS]
						|| control_reg[`CTL_LAST_CHAR])) begin
						stop_latch_reg <= 1'b1;
					end
					if (stop_latch_reg) begin
						mot_reg <= M_STOP;
						stop_signal <= 1'b1;
						stop_cnt_reg <= 8'h00;
					end
				end
				M_STOP: begin
					// Same sequence whatever the mode or direction
					if (stop_cnt_reg == `STOP_CYCLES - 1) begin
						motor_run <= 1'b0;
						stop_signal <= 1'b0;
						stop_latch_reg <= 1'b0;
						mot_reg <= late_pend_reg ? M_BACK : M_IDLE;
					end else begin
						stop_cnt_reg <= stop_cnt_reg + 8'h01;
					end
				end
				M_BACK: begin
					// Hardware-only backspace; the held character is retried on restart
					backspace <= 1'b1;
					late_pend_reg <= 1'b0;
					mot_reg <= M_IDLE;
				end
				default: mot_reg <= M_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control, diagnostic latches, new line and input register

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control_reg <= `CTL_RESET;
			diag_control_reg <= `DIAG_RESET;
			diag_lines <= `DIAG_RESET;
			new_line <= 1'b0;
			mem_index_reg <= 8'h00;
			host_input_reg <= 8'h00;
		end else begin
			new_line <= 1'b0;
			diag_lines <= diag_control_reg;
			if (wr_acc && paddr[31:8] == 24'h000000) begin
				case (reg_off)
					`OFF_CONTROL: control_reg <= pwdata[2:0];
					`OFF_DIAG_CONTROL: begin
						diag_control_reg <= pwdata[7:0];
						// New line skips translation entirely
						if (pwdata[7:0] == `DIAG_NEW_LINE) begin
							new_line <= 1'b1;
						end
					end
					`OFF_MEM_INDEX: mem_index_reg <= pwdata[7:0];
					default: mem_index_reg <= mem_index_reg;
				endcase
			end
			// Keyboard codes enter untranslated; diagnostics may select status lines
			if (diag_control_reg[`DIAG_SEL_STATUS]) begin
				host_input_reg <= {2'b00, backspace, late_pend_reg, stop_latch_reg,
					motor_run, data_ready, seq_reg != S_IDLE};
			end else if (kb_strobe) begin
				host_input_reg <= kb_char;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// APB slave: data prepared in setup, answered in access with pready high

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (rd_setup) begin
			pready <= 1'b1;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			if (paddr[31:8] != 24'h000000 || paddr[1:0] != 2'b00) begin
				pslverr <= 1'b1;
			end else begin
				case (reg_off)
					`OFF_CHAR_CODE: prdata <= {24'h000000, char_reg};
					`OFF_CONTROL: prdata <= {29'h0, control_reg};
					`OFF_DIAG_CONTROL: prdata <= {24'h000000, diag_control_reg};
					`OFF_STATUS: prdata <= {26'h0, backspace, late_pend_reg, stop_latch_reg,
						motor_run, data_ready, seq_reg != S_IDLE};
					`OFF_WORD1: prdata <= word1_reg;
					`OFF_WORD2: prdata <= word2_reg;
					`OFF_HOST_INPUT: prdata <= {24'h000000, host_input_reg};
					`OFF_IMAGE_ADDR: prdata <= {16'h0000, img_addr_reg};
					`OFF_MEM_INDEX: prdata <= {24'h000000, mem_index_reg};
					`OFF_MEM_DATA: prdata <= mem_rd_word;
					default: pslverr <= 1'b1;
				endcase
			end
		end else begin
			// Ready drops after the access edge; a new setup is needed
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end
endmodule // char_to_dot_matrix_loader
`default_nettype wire

/* test/dm_props.sv */
// Port checker for the dot-matrix loader
`timescale 1ns/1ns
`default_nettype none
module dm_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pe_pulse,
	input wire logic [6:0] print_wire,
	input wire logic load_first_half_strobe,
	input wire logic load_pair_strobe,
	input wire logic data_ready,
	input wire logic stop_signal,
	input wire logic backspace,
	input wire logic new_line
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////
	// The two word loads of one character
	sequence first_load;
		load_first_half_strobe && load_pair_strobe;
	endsequence
	sequence second_load;
		load_pair_strobe && !load_first_half_strobe;
	endsequence
	a_answer_next: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	a_pready_one: assert property (pready |=> !pready)
		else $error("pready held too long");
	a_strobe_pair: assert property (load_first_half_strobe |-> load_pair_strobe)
		else $error("first strobe without pair strobe");
	a_load_order: assert property (first_load |=> second_load)
		else $error("second word load missing");
	a_ready_after: assert property (first_load ##1 second_load |-> ##[0:1] data_ready)
		else $error("data ready late");
	a_newline_pulse: assert property (psel && penable && pready && pwrite
		&& paddr == 32'h8 && pwdata[7:0] == 8'h08 |-> ##[1:2] new_line)
		else $error("no new line pulse");
	a_stop_span: assert property ($rose(stop_signal) |-> stop_signal[*4] ##1 !stop_signal)
		else $error("stop sequence length wrong");
	a_bs_pulse: assert property (backspace |=> !backspace)
		else $error("backspace longer than a cycle");
	a_wire_gated: assert property (print_wire != 7'h0 |-> $past(pe_pulse))
		else $error("wires fired without emitter pulse");
endmodule // dm_props
`default_nettype wire

/* test/head_model.sv */
// Behavioural print head: emitter pulses while the motor steps
`timescale 1ns/1ns
`default_nettype none
module head_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic motor_run,
	input wire logic stop_signal,
	input wire logic new_line,
	input wire logic [3:0] gap,
	output logic pe_pulse
);
	logic [3:0] cnt;
	int lines;
	// Emitter only turns with the motor, so it is still between sweeps
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 4'h0;
			pe_pulse <= 1'b0;
			lines <= 0;
		end else begin
			cnt <= (motor_run && !stop_signal && cnt < gap) ? cnt + 4'h1 : 4'h0;
			pe_pulse <= motor_run && !stop_signal && cnt == gap;
			lines <= lines + new_line;
		end
	end
endmodule // head_model
`default_nettype wire

/* test/tb_char_to_dot_matrix_loader.sv */
// Self-checking bench for the dot-matrix loader
`timescale 1ns/1ns
`default_nettype none
module tb_char_to_dot_matrix_loader;
	logic pclk, presetn, psel, penable, pwrite, pe_pulse, kb_strobe, rev, gated;
	logic [31:0] paddr, pwdata, prdata;
	logic [7:0] kb_char, diag_lines, c;
	logic [6:0] print_wire;
	logic [3:0] gap;
	logic pready, pslverr, load_first_half_strobe, load_pair_strobe, data_ready;
	logic motor_run, motor_reverse, stop_signal, backspace, new_line;
	logic [32:0] rq[$];
	logic [6:0] pq[$];
	logic [7:0] codes[6] = '{8'hc7, 8'h81, 8'h25, 8'hf3, 8'h40, 8'h47};
	int errors, cmp_count, bs_seen;
	char_to_dot_matrix_loader char_to_dot_matrix_loader_inst (.*);
	head_model head_model_inst (.pclk, .presetn, .motor_run, .stop_signal, .new_line,
		.gap, .pe_pulse);
	////////////////////////////////////////////////////////////////
	task chk(input logic [32:0] seen, input logic [32:0] exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One APB transfer; held until pready is sampled high
	task apb(input logic [31:0] a, input logic [31:0] d, input logic w);
		int k;
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		paddr <= a;
		pwdata <= d;
		pwrite <= w;
		@(posedge pclk);
		penable <= 1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		psel <= 0;
		penable <= 0;
	endtask
	task wr(input logic [31:0] a, input logic [31:0] d);
		apb(a, d, 1);
	endtask
	task rd(input logic [31:0] a, input logic [32:0] exp);
		rq.push_back(exp);
		apb(a, 0, 0);
	endtask
	// Index table worked out from the character layout
	function automatic logic [7:0] tbl(input logic [6:0] i);
		if (i >= 7'h40) return {i[4:0], 3'h0};
		if (i <= 7'h09) return {i[4:0], 3'h0};
		if (i >= 7'h11 && i <= 7'h19) return 8'(i - 7'h07) << 3;
		if (i >= 7'h22 && i <= 7'h29) return 8'h98 + (8'(i - 7'h22) << 3);
		return 8'h00;
	endfunction
	task put_char(input logic [7:0] ch, input logic sp);
		logic [7:0] hi, lo;
		logic [31:0] w1, w2;
		int k;
		hi = ch[6] ? (ch[5] ? 8'hba : 8'hb9) : 8'hb8;
		lo = tbl(ch[6:0]);
		w1 = sp ? 32'h0 : $urandom & 32'hfefefefe;
		w2 = sp ? 32'h0 : $urandom & 32'hfefefe00;
		wr(32'h20, (hi - 8'hb8) * 64 + lo / 4);
		wr(32'h24, w1);
		wr(32'h20, (hi - 8'hb8) * 64 + lo / 4 + 1);
		wr(32'h24, w2);
		for (int i = 3; i >= 0; i--) pq.push_back(w1[8 * i + 1 +: 7]);
		for (int i = 3; i >= 1; i--) pq.push_back(w2[8 * i + 1 +: 7]);
		wr(32'h00, {24'h0, ch});
		k = 0;
		while (data_ready !== 1'b1 && k < 50) begin
			@(posedge pclk);
			k++;
		end
		rd(32'h10, {1'b0, w1});
		rd(32'h14, {1'b0, w2});
		rd(32'h1c, {17'h0, hi, lo + 8'h04});
		chk(motor_reverse, rev, "direction");
	endtask
	task wait_idle;
		int k;
		k = 0;
		while (motor_run !== 1'b0 && k < 600) begin
			@(posedge pclk);
			k++;
		end
		repeat (6) @(posedge pclk);
	endtask
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// Read answers and fired wires are checked against the oldest note
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite)
			chk({pslverr, prdata}, rq.pop_front(), "read");
		gated <= pe_pulse && motor_run && data_ready;
		if (gated)
			chk(print_wire, pq.pop_front(), "wire");
		if (backspace)
			bs_seen++;
	end
	initial begin
		pclk = 0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		#300000;
		errors++;
		tally_and_finish;
	end
	initial begin
		{presetn, psel, penable, pwrite, kb_strobe, rev} = 0;
		{paddr, pwdata, kb_char} = 0;
		gap = 4'h2;
		void'($urandom(32'h8341));
		repeat (10) @(posedge pclk);
		presetn <= 1;
		rd(32'h04, 0);
		rd(32'h08, 0);
		rd(32'h0c, 0);
		rd(32'h28, {1'b1, 32'h0});
		$display("test reset done");
		foreach (codes[i]) begin
			rev = i[0];
			wr(32'h04, {30'h0, rev, 1'b0});
			put_char(codes[i], codes[i] == 8'h40);
			wait_idle;
		end
		$display("test translate done");
		wr(32'h08, 32'h08);
		repeat (3) @(posedge pclk);
		chk(diag_lines, 8'h08, "diag lines");
		chk(head_model_inst.lines, 1, "new lines");
		wr(32'h08, 0);
		c = $urandom;
		kb_char <= c;
		kb_strobe <= 1;
		@(posedge pclk);
		kb_strobe <= 0;
		rd(32'h18, {25'h0, c});
		$display("test diag done");
		rev = 0;
		gap <= 4'h9;
		wr(32'h04, 1);
		put_char(8'hc1, 0);
		wait_idle;
		chk(bs_seen, 1, "late backspace");
		wr(32'h04, 5);
		put_char(8'hc2, 0);
		wait_idle;
		chk(bs_seen, 1, "retry clean");
		$display("test late data done");
		tally_and_finish;
	end
endmodule // tb_char_to_dot_matrix_loader
bind char_to_dot_matrix_loader dm_props dm_props_inst (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pready, .pe_pulse, .print_wire, .load_first_half_strobe,
	.load_pair_strobe, .data_ready, .stop_signal, .backspace, .new_line);
`default_nettype wire
